// ==== rtl/sisl_top.sv ====
// Supervisory command gating, source combining and status contact drive
`timescale 1ns/1ps
module sisl_top #(
	parameter int QUAL_CYC_P = sisl_pkg::QUAL_CYC
) (
	input  wire logic                           core_clk_in,
	input  wire logic                           sys_rst_in,
	input  wire sisl_pkg::sisl_pins_t           pins_in,
	input  wire logic                           ctrl_ok_in,
	input  wire logic                           fault_lockout_in,
	input  wire logic                           reclose_ivl_in,
	input  wire logic                           reset_expired_in,
	input  wire logic                           nv_tag_in,
	input  wire logic [sisl_pkg::ADDR_W-1:0]    addr_in,
	input  wire logic [sisl_pkg::DATA_W-1:0]    wr_data_in,
	input  wire logic                           wr_in,
	input  wire logic                           rd_in,
	output logic      [sisl_pkg::DATA_W-1:0]    rd_data_out,
	output logic                                trip_cmd_out,
	output logic                                close_cmd_out,
	output logic                                close_inhibit_out,
	output logic                                cancel_reclose_out,
	output logic                                one_shot_out,
	output sisl_pkg::sisl_curve_t               curve_sel_out,
	output logic                                gnd_trip_block_out,
	output logic                                nv_tag_out,
	output sisl_pkg::sisl_stat_t                stat_out
);
	import sisl_pkg::*;

	logic [NPINS-1:0] lvl_v;
	logic [NPINS-1:0] rise_v;
	logic [NPINS-1:0] fall_v;
	sisl_pins_t       lvl;
	sisl_pins_t       rise;
	sisl_pins_t       fall;

	// Every pin is synchronised and width-qualified before use
	sisl_qual #(
		.W   (NPINS),
		.CYC (QUAL_CYC_P)
	) u_qual (
		.core_clk_in (core_clk_in),
		.sys_rst_in  (sys_rst_in),
		.raw_in      (pins_in),
		.lvl_out     (lvl_v),
		.rise_out    (rise_v),
		.fall_out    (fall_v)
	);
	assign lvl  = lvl_v;
	assign rise = rise_v;
	assign fall = fall_v;

	// State
	logic        lockout_r,    lockout_nxt;
	logic        cold_load_r,  cold_load_nxt;
	logic        sup_gtb_r,    sup_gtb_nxt;
	logic        sup_nr_r,     sup_nr_nxt;
	logic        ser_gtb_r,    ser_gtb_nxt;
	logic        ser_nr_r,     ser_nr_nxt;
	logic        sup_tag_r,    sup_tag_nxt;
	logic        tag_prev_r;
	logic        nv_loaded_r;
	logic        cold_en_r;

	// Supervisory enable and signalling mode
	wire sup_en   = lvl.sw_sup_on;
	wire mom_mode = lvl.sw_pulse;

	// Line-work tag from panel or supervisory latch
	wire tag_act  = lvl.sw_tag | sup_tag_r;
	wire tag_rise = tag_act && !tag_prev_r;

	// Trip sources: remote ignores the enable, supervisory needs it, panel never does
	wire rem_trip  = rise.rem_trip;
	wire sup_trip  = rise.sup_trip && sup_en;
	wire man_trip  = rise.sw_man_trip;
	wire tag_lock  = tag_rise && reclose_ivl_in;
	wire any_trip  = rem_trip | sup_trip | man_trip;

	// Close sources, all held off by the tag; releases do nothing
	wire sup_close = rise.sup_close && sup_en && !tag_act;
	wire man_close = rise.sw_man_close && !tag_act;
	wire any_close = (sup_close | man_close) && !any_trip;

	// Lockout: set wins over close
	assign lockout_nxt = any_trip | tag_lock | fault_lockout_in ? 1'b1 :
	                     any_close ? 1'b0 : lockout_r;

	// Cold-load one-shot after a close, one shared disable setting
	assign cold_load_nxt = any_close ? cold_en_r :
	                       (reset_expired_in || any_trip) ? 1'b0 : cold_load_r;

	// Supervisory ground block and non-reclose requests: toggle or follow level
	assign sup_gtb_nxt = !sup_en   ? sup_gtb_r :
	                     mom_mode  ? sup_gtb_r ^ rise.sup_gtb :
	                     lvl.sup_gtb;
	assign sup_nr_nxt  = !sup_en   ? sup_nr_r :
	                     mom_mode  ? sup_nr_r ^ rise.sup_nr :
	                     lvl.sup_nr;

	// Combined feature states
	wire gtb_act = lvl.sw_gtb | ser_gtb_r | (sup_gtb_r && sup_en);
	wire nr_act  = lvl.sw_nr  | ser_nr_r  | (sup_nr_r  && sup_en);

	// Supervisory tag latch: set wins even when already held, enable not consulted
	assign sup_tag_nxt = !nv_loaded_r ? nv_tag_in :
	                     rise.tag_set ? 1'b1 :
	                     (rise.tag_rst && !lvl.tag_set) ? 1'b0 : sup_tag_r;

	// Curve selection: tag overrides cold-load; non-reclose feeds only the one-shot
	wire sisl_curve_t curve_nxt = tag_act     ? SISL_CURVE_DEFINITE :
	                              cold_load_r ? SISL_CURVE_COLD_LOAD : SISL_CURVE_NORMAL;
	wire one_shot_nxt = tag_act | cold_load_r | nr_act;

	// Register bus decode
	wire wr_cfg = wr_in && (addr_in == REG_CFG);
	wire wr_ser = wr_in && (addr_in == REG_SERIAL);
	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		if (addr_in == REG_CFG) begin
			rd_mux = {31'h0, cold_en_r};
		end else if (addr_in == REG_SERIAL) begin
			rd_mux = {30'h0, ser_nr_r, ser_gtb_r};
		end else if (addr_in == REG_STATUS) begin
			rd_mux = {22'h0, curve_sel_out, one_shot_out, tag_act, nr_act, gtb_act,
			          cold_load_r, lockout_r, sup_en, mom_mode};
		end else begin
			rd_mux = '0;
		end
	end

	// Serial-port requests: own set and clear only, set wins
	assign ser_gtb_nxt = wr_ser && wr_data_in[SER_GTB_SET] ? 1'b1 :
	                     wr_ser && wr_data_in[SER_GTB_CLR] ? 1'b0 : ser_gtb_r;
	assign ser_nr_nxt  = wr_ser && wr_data_in[SER_NR_SET]  ? 1'b1 :
	                     wr_ser && wr_data_in[SER_NR_CLR]  ? 1'b0 : ser_nr_r;

	// Feature state registers; momentary latches clear at power-up
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			lockout_r   <= 1'b0;
			cold_load_r <= 1'b0;
			sup_gtb_r   <= 1'b0;
			sup_nr_r    <= 1'b0;
			ser_gtb_r   <= 1'b0;
			ser_nr_r    <= 1'b0;
			sup_tag_r   <= 1'b0;
			tag_prev_r  <= 1'b0;
			nv_loaded_r <= 1'b0;
			cold_en_r   <= CFG_COLD_RST;
		end else begin
			lockout_r   <= lockout_nxt;
			cold_load_r <= cold_load_nxt;
			sup_gtb_r   <= sup_gtb_nxt;
			sup_nr_r    <= sup_nr_nxt;
			ser_gtb_r   <= ser_gtb_nxt;
			ser_nr_r    <= ser_nr_nxt;
			sup_tag_r   <= sup_tag_nxt;
			tag_prev_r  <= tag_act;
			nv_loaded_r <= 1'b1;
			cold_en_r   <= wr_cfg ? wr_data_in[CFG_COLD_EN] : cold_en_r;
		end
	end

	// Command and status outputs, all registered
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			rd_data_out        <= '0;
			trip_cmd_out       <= 1'b0;
			close_cmd_out      <= 1'b0;
			close_inhibit_out  <= 1'b0;
			cancel_reclose_out <= 1'b0;
			one_shot_out       <= 1'b0;
			curve_sel_out      <= SISL_CURVE_NORMAL;
			gnd_trip_block_out <= 1'b0;
			nv_tag_out         <= 1'b0;
			stat_out           <= '{gnd_normal: 1'b1, default: 1'b0};
		end else begin
			rd_data_out        <= rd_in ? rd_mux : '0;
			trip_cmd_out       <= any_trip;
			close_cmd_out      <= any_close;
			close_inhibit_out  <= tag_act;
			cancel_reclose_out <= tag_lock;
			one_shot_out       <= one_shot_nxt;
			curve_sel_out      <= curve_nxt;
			gnd_trip_block_out <= gtb_act;
			nv_tag_out         <= sup_tag_nxt;
			stat_out.sup_on      <= sup_en;
			stat_out.rec_open    <= lvl.sen_open;
			stat_out.rec_closed  <= lvl.sen_closed;
			stat_out.lockout     <= lockout_r;
			stat_out.ctrl_ok     <= ctrl_ok_in;
			stat_out.gnd_blocked <= gtb_act;
			stat_out.gnd_normal  <= !gtb_act;
			stat_out.non_reclose <= nr_act;
			stat_out.line_tag    <= tag_act;
		end
	end

	// Checks on the control behaviour
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);

	property p_sup_gate;
		rise.sup_trip && !sup_en && !rise.rem_trip && !rise.sw_man_trip |=> !trip_cmd_out;
	endproperty
	a_sup_gate: assert property (p_sup_gate) else $error("supervisory trip acted while disabled");

	property p_man_trip;
		rise.sw_man_trip |=> trip_cmd_out ##1 stat_out.lockout;
	endproperty
	a_man_trip: assert property (p_man_trip) else $error("panel trip did not trip and lock out");

	property p_rem_trip;
		rise.rem_trip && !sup_en |=> trip_cmd_out && lockout_r;
	endproperty
	a_rem_trip: assert property (p_rem_trip) else $error("remote trip ignored while disabled");

	property p_lock_hold;
		lockout_r && !rise.sup_close && !rise.sw_man_close |=> lockout_r;
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lockout left without a close");

	property p_cold_load;
		any_close && cold_en_r |=> cold_load_r && close_cmd_out ##1
			(curve_sel_out == SISL_CURVE_COLD_LOAD || tag_prev_r);
	endproperty
	a_cold_load: assert property (p_cold_load) else $error("close did not select cold-load curve");

	property p_cold_end;
		cold_load_r && reset_expired_in && !any_close |=> !cold_load_r;
	endproperty
	a_cold_end: assert property (p_cold_end) else $error("cold-load kept past reset interval");

	property p_tag_block;
		tag_act |=> !close_cmd_out && close_inhibit_out;
	endproperty
	a_tag_block: assert property (p_tag_block) else $error("close issued under line-work tag");

	property p_tag_clear;
		!lvl.sw_tag && !sup_tag_r |=> !close_inhibit_out;
	endproperty
	a_tag_clear: assert property (p_tag_clear) else $error("tag held with no source");

	property p_tag_set_wins;
		nv_loaded_r && lvl.tag_set && rise.tag_rst |=> sup_tag_r ##1 stat_out.line_tag;
	endproperty
	a_tag_set_wins: assert property (p_tag_set_wins) else $error("tag reset beat set");

	property p_gnd_pair;
		stat_out.gnd_normal != stat_out.gnd_blocked;
	endproperty
	a_gnd_pair: assert property (p_gnd_pair) else $error("ground changeover pair inconsistent");

	property p_release;
		fall.sup_close && !rise.sw_man_close |=> !close_cmd_out;
	endproperty
	a_release: assert property (p_release) else $error("release of close caused a close");

	property p_tag_ivl;
		tag_rise && reclose_ivl_in |=> cancel_reclose_out && lockout_r;
	endproperty
	a_tag_ivl: assert property (p_tag_ivl) else $error("tag in reclose interval not locked out");

	c_sup_close: cover property (sup_close ##1 close_cmd_out);
	c_tag_ivl:   cover property (tag_lock);
	c_nr_mom:    cover property (mom_mode && sup_en && rise.sup_nr ##1 nr_act);
	c_gtb_ser:   cover property (wr_ser ##1 ser_gtb_r);
endmodule : sisl_top

// ==== rtl/sisl_pkg.sv ====
// Constants, types and carriers shared by the supervisory input and status logic
//
// Functional notes
// - Enable gates all enable-dependent supervisory commands
// - Panel trip and close ignore supervisory enable
// - Remote trip locks out regardless of enable
// - Supervisory trip locks out until any close
// - Supervisory close forces cold-load one-shot until reset
// - One cold-load disable covers panel and supervisory
// - Ground block depends on panel switch, enable
// - Momentary non-reclose pulse gives one-shot lockout
// - Momentary non-reclose clears at power-up
// - Maintained non-reclose follows contact while enabled
// - Non-reclose while closed gives one-shot lockout
// - Ground block and non-reclose OR three sources
// - Each source clears only its own request
// - Tag blocks closing, forces definite one-shot
// - Tag during reclose interval cancels, locks out
// - Tag is panel OR supervisory, both clear
// - Separate set/reset pulses, set wins, ungated
// - Supervisory tag survives total power loss
// - Status contacts mirror enable, position, lockout, health
// - Status contacts open while unpowered or reset, except ground normal
// - Ground changeover pair, normal closed unpowered
// - Non-reclose and tag status contacts, panel included
// - Input release causes no automatic operation
package sisl_pkg;
	// Timing of contact qualification
	localparam int     QUAL_MIN_MS = 100;
	localparam longint CLK_HZ      = 64'd50_000_000;
	localparam int     QUAL_CYC    = int'((64'(QUAL_MIN_MS) * CLK_HZ + 64'd999) / 64'd1000);
	localparam int     CNT_W       = 24;
	// Register bus layout
	localparam int          ADDR_W      = 4;
	localparam int          DATA_W      = 32;
	localparam logic [3:0]  REG_CFG     = 4'h0;
	localparam logic [3:0]  REG_SERIAL  = 4'h4;
	localparam logic [3:0]  REG_STATUS  = 4'h8;
	localparam int          CFG_COLD_EN = 0;
	localparam logic        CFG_COLD_RST = 1'b1;
	localparam int          SER_GTB_SET = 0;
	localparam int          SER_GTB_CLR = 1;
	localparam int          SER_NR_SET  = 2;
	localparam int          SER_NR_CLR  = 3;
	localparam int          NPINS       = 16;

	// Protection curve selection
	typedef enum logic [1:0] {
		SISL_CURVE_NORMAL    = 2'b00,
		SISL_CURVE_COLD_LOAD = 2'b01,
		SISL_CURVE_DEFINITE  = 2'b10
	} sisl_curve_t;

	// Dry-contact and panel pin inputs, all asynchronous
	typedef struct packed {
		logic rem_trip;
		logic sup_trip;
		logic sup_close;
		logic sup_gtb;
		logic sup_nr;
		logic tag_set;
		logic tag_rst;
		logic sw_sup_on;
		logic sw_pulse;
		logic sw_man_trip;
		logic sw_man_close;
		logic sw_gtb;
		logic sw_nr;
		logic sw_tag;
		logic sen_open;
		logic sen_closed;
	} sisl_pins_t;

	// Status contact outputs, 1 = contact closed
	typedef struct packed {
		logic sup_on;
		logic rec_open;
		logic rec_closed;
		logic lockout;
		logic ctrl_ok;
		logic gnd_blocked;
		logic gnd_normal;
		logic non_reclose;
		logic line_tag;
	} sisl_stat_t;
endpackage : sisl_pkg

// ==== rtl/sisl_qual.sv ====
// Two-stage synchroniser and pulse-width qualifier for contact inputs
`timescale 1ns/1ps
module sisl_qual #(
	parameter int W   = 16,
	parameter int CYC = sisl_pkg::QUAL_CYC
) (
	input  wire logic                   core_clk_in,
	input  wire logic                   sys_rst_in,
	input  wire logic [W-1:0]           raw_in,
	output logic      [W-1:0]           lvl_out,
	output logic      [W-1:0]           rise_out,
	output logic      [W-1:0]           fall_out
);
	import sisl_pkg::*;

	localparam logic [CNT_W-1:0] CNT_END = CNT_W'(CYC - 1);

	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// Two flip-flops before anything reads the pins
	always_ff @(posedge core_clk_in) begin
		meta_r <= raw_in;
		sync_r <= meta_r;
	end

	// One counter per input: a level is taken only after it held for CYC cycles
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic [CNT_W-1:0] cnt_r;
		wire              differs = sync_r[i] != lvl_out[i];
		wire              done    = differs && (cnt_r == CNT_END);
		always_ff @(posedge core_clk_in) begin
			if (sys_rst_in) begin
				cnt_r       <= '0;
				lvl_out[i]  <= 1'b0;
				rise_out[i] <= 1'b0;
				fall_out[i] <= 1'b0;
			end else begin
				cnt_r       <= (differs && !done) ? cnt_r + 1'b1 : '0;
				lvl_out[i]  <= done ? sync_r[i] : lvl_out[i];
				rise_out[i] <= done && sync_r[i];
				fall_out[i] <= done && !sync_r[i];
			end
		end
	end
endmodule : sisl_qual

// ==== test/sisl_scada_model.sv ====
// Remote supervisory dry-contact model driving the supervisory command pins
`timescale 1ns/1ps
module sisl_scada_model #(
	parameter int MIN_CYC = 10
) (
	input  wire logic            core_clk_in,
	output sisl_pkg::sisl_pins_t sup_out
);
	import sisl_pkg::*;
	logic [6:0] cont_r;
	// Contacts fill the top seven pin positions; an open contact reads low
	assign sup_out = sisl_pins_t'({cont_r, 9'h000});
	initial cont_r = 7'h00;
	// Move one contact just after a clock edge
	task automatic set_lvl(input int b, input logic v);
		@(posedge core_clk_in);
		cont_r[b] <= v;
	endtask : set_lvl
	// Close a contact for at least the minimum width, then open it
	task automatic pulse(input int b);
		set_lvl(b, 1'b1);
		repeat (MIN_CYC) @(posedge core_clk_in);
		set_lvl(b, 1'b0);
	endtask : pulse
endmodule : sisl_scada_model

// ==== test/tb_top.sv ====
// Self-checking bench for the supervisory input and status logic
`timescale 1ns/1ps
module tb_top;
	import sisl_pkg::*;
	logic              core_clk_in, sys_rst_in, ctrl_ok, flt_lo, rcl_ivl, rst_exp, nv_tag;
	logic              wr, rd, trip, close, inhibit, cancel, one_shot, gtb, nv_out;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, rv;
	sisl_pins_t        pan, sup;
	sisl_curve_t       curve;
	sisl_stat_t        st;
	int                n_fail, cmp_count, n_trip, n_close, n_cancel;
	// Clock and one-cycle command pulse counters
	always #10 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) begin
		n_trip   <= n_trip + int'(trip === 1'b1);
		n_close  <= n_close + int'(close === 1'b1);
		n_cancel <= n_cancel + int'(cancel === 1'b1);
	end
	sisl_scada_model #(.MIN_CYC(10)) scada_u (.core_clk_in(core_clk_in), .sup_out(sup));
	sisl_top #(.QUAL_CYC_P(4)) dut_u (
		.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .pins_in(sisl_pins_t'(pan | sup)),
		.ctrl_ok_in(ctrl_ok), .fault_lockout_in(flt_lo), .reclose_ivl_in(rcl_ivl),
		.reset_expired_in(rst_exp), .nv_tag_in(nv_tag), .addr_in(addr), .wr_data_in(wdata),
		.wr_in(wr), .rd_in(rd), .rd_data_out(rdata), .trip_cmd_out(trip), .close_cmd_out(close),
		.close_inhibit_out(inhibit), .cancel_reclose_out(cancel), .one_shot_out(one_shot),
		.curve_sel_out(curve), .gnd_trip_block_out(gtb), .nv_tag_out(nv_out), .stat_out(st));
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask : cyc
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge core_clk_in);
		wr <= 1'b0;
		cyc(2);
	endtask : reg_wr
	task automatic reg_rd(input logic [3:0] a);
		@(posedge core_clk_in);
		rd   <= 1'b1;
		addr <= a;
		@(posedge core_clk_in);
		rd <= 1'b0;
		#1 rv = rdata;
	endtask : reg_rd
	// Hold reset for 12 cycles with the stored tag presented
	task automatic do_reset(input logic t);
		@(posedge core_clk_in);
		sys_rst_in <= 1'b1;
		nv_tag     <= t;
		repeat (12) @(posedge core_clk_in);
		sys_rst_in <= 1'b0;
		cyc(16);
	endtask : do_reset
	// Panel pin by bit position, then let it qualify
	task automatic setp(input int b, input logic v);
		@(posedge core_clk_in);
		pan[b] <= v;
		cyc(14);
	endtask : setp
	task automatic pw(input int b);
		scada_u.pulse(b);
		cyc(14);
	endtask : pw
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	// Watchdog far beyond the expected thousand or so cycles
	initial begin
		repeat (30000) @(posedge core_clk_in);
		n_fail++;
		$display("watchdog expired");
		stop_test;
	end
	// Pin bits: 6 rem trip, 5 sup trip, 4 sup close, 3 sup gtb, 2 sup nr, 1 tag set, 0 tag reset
	// Panel bits: 8 enable, 7 momentary, 6 trip, 5 close, 4 gtb, 2 tag, 1 open, 0 closed
	initial begin
		{core_clk_in, sys_rst_in, ctrl_ok, flt_lo, rcl_ivl, rst_exp, nv_tag, wr, rd} = 9'h080;
		{addr, wdata, pan} = '0;
		{n_fail, cmp_count, n_trip, n_close, n_cancel} = '0;
		do_reset(1'b0);
		chk("stat", 9'h004, st);
		chk("curve", SISL_CURVE_NORMAL, curve);
		reg_rd(REG_CFG);
		chk("cfg", 32'h1, rv);
		reg_rd(4'hC);
		chk("unmapped", 32'h0, rv);
		$display("test reset done");
		pw(5);
		chk("sup trip off", 0, n_trip);
		pw(6);
		chk("remote trip", 1, n_trip);
		chk("lockout", 1, st.lockout);
		scada_u.set_lvl(6, 1'b1);
		scada_u.set_lvl(6, 1'b0);
		cyc(14);
		chk("short pulse", 1, n_trip);
		pw(4);
		chk("close off", 0, n_close);
		$display("test enable off done");
		setp(8, 1'b1);
		chk("sup_on", 1, st.sup_on);
		pw(5);
		chk("sup trip", 2, n_trip);
		pw(4);
		chk("sup close", 1, n_close);
		chk("unlock", 0, st.lockout);
		chk("cold curve", SISL_CURVE_COLD_LOAD, curve);
		chk("one shot", 1, one_shot);
		chk("release", 2, n_trip);
		reg_rd(REG_STATUS);
		chk("status word", 32'h18A, rv);
		@(posedge core_clk_in);
		rst_exp <= 1'b1;
		@(posedge core_clk_in);
		rst_exp <= 1'b0;
		flt_lo  <= 1'b1;
		@(posedge core_clk_in);
		flt_lo <= 1'b0;
		cyc(4);
		chk("curve back", SISL_CURVE_NORMAL, curve);
		chk("seq lockout", 1, st.lockout);
		reg_wr(REG_CFG, 32'h0);
		setp(5, 1'b1);
		setp(5, 1'b0);
		chk("panel close", 2, n_close);
		chk("no cold", SISL_CURVE_NORMAL, curve);
		pw(4);
		chk("sup no cold", SISL_CURVE_NORMAL, curve);
		reg_wr(REG_CFG, 32'h1);
		setp(8, 1'b0);
		setp(6, 1'b1);
		setp(6, 1'b0);
		chk("panel trip", 3, n_trip);
		$display("test trip close done");
		pw(3);
		chk("gtb off", 0, gtb);
		setp(8, 1'b1);
		setp(7, 1'b1);
		reg_wr(REG_SERIAL, 32'h1);
		chk("serial gtb", 1, gtb);
		reg_rd(REG_SERIAL);
		chk("serial read", 32'h1, rv);
		chk("gnd pair", 2'b10, {st.gnd_blocked, st.gnd_normal});
		pw(3);
		reg_wr(REG_SERIAL, 32'h2);
		chk("gtb sup holds", 1, gtb);
		pw(3);
		chk("gtb toggle", 0, gtb);
		setp(4, 1'b1);
		reg_wr(REG_SERIAL, 32'h2);
		chk("gtb panel", 1, gtb);
		setp(4, 1'b0);
		chk("gnd pair", 2'b01, {st.gnd_blocked, st.gnd_normal});
		pw(2);
		chk("nr", 1, st.non_reclose);
		chk("nr one shot", 1, one_shot);
		reg_wr(REG_SERIAL, 32'hC);
		pw(2);
		chk("nr serial", 1, st.non_reclose);
		reg_wr(REG_SERIAL, 32'h8);
		chk("nr clear", 0, st.non_reclose);
		pw(2);
		do_reset(1'b0);
		chk("nr power", 0, st.non_reclose);
		setp(7, 1'b0);
		setp(8, 1'b0);
		scada_u.set_lvl(2, 1'b1);
		cyc(14);
		chk("held off", 0, st.non_reclose);
		setp(8, 1'b1);
		chk("held on", 1, st.non_reclose);
		do_reset(1'b0);
		chk("held power", 1, st.non_reclose);
		scada_u.set_lvl(2, 1'b0);
		cyc(14);
		chk("held open", 0, st.non_reclose);
		$display("test ground and reclose done");
		setp(5, 1'b1);
		setp(5, 1'b0);
		setp(8, 1'b0);
		pw(1);
		chk("tag", 1, inhibit);
		chk("tag stat", 1, st.line_tag);
		chk("tag curve", SISL_CURVE_DEFINITE, curve);
		chk("tag one shot", 1, one_shot);
		setp(5, 1'b1);
		setp(5, 1'b0);
		chk("tag blocks", 4, n_close);
		chk("tag no trip", 3, n_trip);
		scada_u.set_lvl(1, 1'b1);
		scada_u.set_lvl(0, 1'b1);
		cyc(14);
		scada_u.set_lvl(0, 1'b0);
		scada_u.set_lvl(1, 1'b0);
		cyc(14);
		chk("set wins", 1, inhibit);
		setp(2, 1'b1);
		pw(0);
		chk("sup tag off", 0, nv_out);
		chk("panel holds", 1, inhibit);
		setp(2, 1'b0);
		chk("tag clear", 0, inhibit);
		@(posedge core_clk_in);
		rcl_ivl <= 1'b1;
		pw(1);
		chk("cancel", 1, n_cancel);
		chk("ivl lockout", 1, st.lockout);
		@(posedge core_clk_in);
		rcl_ivl <= 1'b0;
		do_reset(1'b1);
		chk("tag kept", 1, inhibit);
		pw(0);
		chk("tag reset", 0, inhibit);
		$display("test tag done");
		@(posedge core_clk_in);
		ctrl_ok <= 1'b1;
		setp(1, 1'b1);
		chk("open ok", 2'b11, {st.rec_open, st.ctrl_ok});
		setp(1, 1'b0);
		setp(0, 1'b1);
		chk("closed", 2'b01, {st.rec_open, st.rec_closed});
		$display("test status done");
		stop_test;
	end
endmodule : tb_top
